// [src/mcgs_defs.svh]
// Constants for the clock generation and selection block.
// Assumes a 20 MHz system clock and Wishbone byte addresses.
`ifndef MCGS_DEFS_SVH
`define MCGS_DEFS_SVH

// Register byte offsets
`define MCGS_ADR_CTL0 8'h00
`define MCGS_ADR_CTL1 8'h04
`define MCGS_ADR_CTL2 8'h08
`define MCGS_ADR_OSC40 8'h0C
`define MCGS_ADR_PCLK 8'h10
`define MCGS_ADR_PSTOP 8'h14
`define MCGS_ADR_PM2 8'h18
`define MCGS_ADR_PROT 8'h1C
`define MCGS_ADR_MISC 8'h20
`define MCGS_ADR_STAT 8'h24

// CTL0 fields
`define MCGS_B_CLOCK_OUTPUT_PIN_LO 0
`define MCGS_B_CLOCK_OUTPUT_PIN_HI 1
`define MCGS_B_F1_STOP_WAIT 2
`define MCGS_B_SUB_OFF 3
`define MCGS_B_SUB_PIN 4
`define MCGS_B_MAIN_STOP 5
`define MCGS_B_DIV8 6
`define MCGS_B_SRC_SUB 7
// CTL1 fields
`define MCGS_B_STOP_ENTER 0
`define MCGS_B_OSC125_OFF 4
`define MCGS_B_DIVF_LO 6
`define MCGS_B_DIVF_HI 7
// CTL2 fields
`define MCGS_B_DET_EN 0
`define MCGS_B_ONCHIP_FLAG 1
`define MCGS_B_DET_ACT 7
// OSC40 fields
`define MCGS_B_OSC40_EN 0
`define MCGS_B_ONCHIP_SEL 1
// PCLK field
`define MCGS_B_CLOCK_OUTPUT_PIN_F1 5
// PM2 fields
`define MCGS_B_LOCK 1
`define MCGS_B_SUB_FEED 5
// PROT field
`define MCGS_B_PM2_KEY 1
// MISC fields
`define MCGS_B_SDIV_LO 0
`define MCGS_B_SDIV_HI 1
`define MCGS_B_BCLK_DIS 4
`define MCGS_B_WDT_PROT 7

// Reset values
`define MCGS_RST_CTL0 8'h48
`define MCGS_RST_CTL1 8'h00
`define MCGS_RST_OSC40 8'h00
`define MCGS_RST_PSTOP 7'h00
`define MCGS_RST_DIV 5'h08
`define MCGS_RST_ONCHIP 1'h1

// Divider counts, in source edges
`define MCGS_DIV_OSC40 1'h1
`define MCGS_DIV_SUB32 5'h1F
`define MCGS_DIV_F8 5'h07
`define MCGS_DIV_F32 5'h1F
`define MCGS_DIV_ONE 5'h01
`define MCGS_DIV_TWO 5'h02
`define MCGS_DIV_FOUR 5'h04
`define MCGS_DIV_EIGHT 5'h08
`define MCGS_DIV_SIXTEEN 5'h10

// Clock output select codes
`define MCGS_CO_F1 2'h0
`define MCGS_CO_SUB 2'h1
`define MCGS_CO_F8 2'h2
`define MCGS_CO_F32 2'h3

`define MCGS_NPERIPH 7

`endif

// [src/mcgs_pkg.sv]
// Types shared by the clock generation and selection block.
// Assumes mcgs_defs.svh is compiled alongside.
package mcgs_pkg;

    typedef enum logic [1:0] {
        MCGS_SRC_MAIN = 2'b00,
        MCGS_SRC_O40H = 2'b01,
        MCGS_SRC_O125 = 2'b10,
        MCGS_SRC_SUB = 2'b11
    } mcgs_src_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } mcgs_wb_req_t;

    // One bit per source: high for one clk cycle on each source edge
    typedef struct packed {
        logic main;
        logic osc40;
        logic osc125;
        logic sub;
    } mcgs_ticks_t;

endpackage

// [src/mcgs_clock_gen.sv]
// Clock generation and selection: CPU clock source and divider,
// peripheral clock gating, clock output pins and the clock lock.
// Assumes source clocks arrive as edge ticks synchronous to clk.
`timescale 1ns/1ps
`include "mcgs_defs.svh"

module mcgs_clock_gen
    import mcgs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire mcgs_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire mcgs_ticks_t src_tick,
    input wire logic main_stop_detect,
    input wire logic wait_mode,
    input wire logic ext_bus_mode,
    output logic cpu_clk_en,
    output logic periph_base_en,
    output logic [`MCGS_NPERIPH-1:0] periph_clk_en,
    output logic osc40_periph_en,
    output logic osc40_half_periph_en,
    output logic osc125_periph_en,
    output logic wdt_clk_en,
    output logic sub_div32_en,
    output logic sub_feed_en,
    output logic osc40_run,
    output logic osc125_run,
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic stop_mode_req,
    output logic bus_clock_o,
    output logic bus_clock_oe,
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe
);

    function automatic logic [4:0] cpu_divisor(input logic div8,
                                               input logic [1:0] f);
        if (div8)
            return `MCGS_DIV_EIGHT;
        case (f)
            2'h0: return `MCGS_DIV_ONE;
            2'h1: return `MCGS_DIV_TWO;
            2'h2: return `MCGS_DIV_FOUR;
            default: return `MCGS_DIV_SIXTEEN;
        endcase
    endfunction

    logic [7:0] ctl0_q;
    logic [7:0] ctl1_q;
    logic det_en_q;
    logic det_act_q;
    logic onchip_flag_q;
    logic [7:0] osc40_q;
    logic clock_output_pin_f1_q;
    logic [`MCGS_NPERIPH-1:0] pstop_q;
    logic lock_q;
    logic sub_feed_q;
    logic key_q;
    logic [1:0] sdiv_q;
    logic bclk_dis_q;
    logic wdt_prot_q;
    logic ack_q;
    logic [31:0] dat_q;

    logic wr;
    logic [7:0] wd;
    logic low_speed;
    logic fallback;
    logic osc40_on;
    logic osc125_on;
    logic sub_on;
    logic t_main;
    logic t_osc40;
    logic t_osc125;
    logic t_sub;
    logic half_ph_q;
    logic t_half;
    mcgs_src_t sel_src;
    mcgs_src_t cur_src_q;
    logic [4:0] sel_div;

    // Write lands on the edge where the master sees ack
    assign wr = wb_req.cyc & wb_req.stb & wb_req.we & ack_q & wb_req.sel[0];
    assign wd = wb_req.dat[7:0];
    assign low_speed = ctl0_q[`MCGS_B_SRC_SUB] & ~onchip_flag_q;
    assign fallback = main_stop_detect & det_en_q & det_act_q;

    assign osc40_on = osc40_q[`MCGS_B_OSC40_EN];
    assign osc125_on = ~ctl1_q[`MCGS_B_OSC125_OFF];
    assign sub_on = ctl0_q[`MCGS_B_SUB_PIN];
    assign t_main = src_tick.main & ~ctl0_q[`MCGS_B_MAIN_STOP];
    assign t_osc40 = src_tick.osc40 & osc40_on;
    assign t_osc125 = src_tick.osc125 & osc125_on;
    assign t_sub = src_tick.sub & sub_on;
    assign t_half = t_osc40 & (half_ph_q == `MCGS_DIV_OSC40);

    // Every other 40 MHz edge gives one edge of the halved clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            half_ph_q <= 1'b0;
        else if (t_osc40)
            half_ph_q <= ~half_ph_q;
    end

    // Wishbone slave: one wait state, ack for one cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= wb_req.cyc & wb_req.stb & ~ack_q;
            if (wb_req.cyc & wb_req.stb & ~ack_q) begin
                case (wb_req.adr)
                    `MCGS_ADR_CTL0: dat_q <= {24'h0, ctl0_q};
                    `MCGS_ADR_CTL1: dat_q <= {24'h0, ctl1_q};
                    `MCGS_ADR_CTL2:
                        dat_q <= {24'h0, det_act_q, 5'h0, onchip_flag_q,
                                  det_en_q};
                    `MCGS_ADR_OSC40: dat_q <= {24'h0, osc40_q};
                    `MCGS_ADR_PCLK: dat_q <= {26'h0, clock_output_pin_f1_q, 5'h0};
                    `MCGS_ADR_PSTOP: dat_q <= {25'h0, pstop_q};
                    `MCGS_ADR_PM2:
                        dat_q <= {26'h0, sub_feed_q, 3'h0, lock_q, 1'b0};
                    `MCGS_ADR_PROT: dat_q <= {30'h0, key_q, 1'b0};
                    `MCGS_ADR_MISC:
                        dat_q <= {24'h0, wdt_prot_q, 2'h0, bclk_dis_q, 2'h0,
                                  sdiv_q};
                    `MCGS_ADR_STAT:
                        dat_q <= {24'h0, main_osc_run, sub_osc_run,
                                  osc125_run, osc40_run, 2'h0, cur_src_q};
                    default: dat_q <= 32'h0;
                endcase
            end
        end
    end

    // Control word 0: lockable bits, hardware divide-by-8 set
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            ctl0_q <= `MCGS_RST_CTL0;
        else begin
            if (wr && wb_req.adr == `MCGS_ADR_CTL0) begin
                ctl0_q[`MCGS_B_CLOCK_OUTPUT_PIN_HI:`MCGS_B_CLOCK_OUTPUT_PIN_LO] <=
                    wd[`MCGS_B_CLOCK_OUTPUT_PIN_HI:`MCGS_B_CLOCK_OUTPUT_PIN_LO];
                ctl0_q[`MCGS_B_SUB_OFF] <= wd[`MCGS_B_SUB_OFF];
                ctl0_q[`MCGS_B_SUB_PIN] <= wd[`MCGS_B_SUB_PIN];
                ctl0_q[`MCGS_B_DIV8] <= wd[`MCGS_B_DIV8];
                if (!lock_q) begin
                    ctl0_q[`MCGS_B_F1_STOP_WAIT] <= wd[`MCGS_B_F1_STOP_WAIT];
                    ctl0_q[`MCGS_B_MAIN_STOP] <= wd[`MCGS_B_MAIN_STOP];
                    ctl0_q[`MCGS_B_SRC_SUB] <= wd[`MCGS_B_SRC_SUB];
                    if (wd[`MCGS_B_MAIN_STOP] && low_speed)
                        ctl0_q[`MCGS_B_DIV8] <= 1'b1;
                end
            end
            // Hardware set wins over a software clear in the same cycle
            if (wr && wb_req.adr == `MCGS_ADR_CTL1 && !lock_q &&
                wd[`MCGS_B_STOP_ENTER])
                ctl0_q[`MCGS_B_DIV8] <= 1'b1;
        end
    end

    // Control word 1: stop entry self-clears, osc125 held on in fallback
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctl1_q <= `MCGS_RST_CTL1;
            stop_mode_req <= 1'b0;
        end else begin
            stop_mode_req <= wr && wb_req.adr == `MCGS_ADR_CTL1 &&
                             !lock_q && wd[`MCGS_B_STOP_ENTER];
            if (wr && wb_req.adr == `MCGS_ADR_CTL1) begin
                ctl1_q[`MCGS_B_DIVF_HI:`MCGS_B_DIVF_LO] <=
                    wd[`MCGS_B_DIVF_HI:`MCGS_B_DIVF_LO];
                ctl1_q[`MCGS_B_OSC125_OFF] <= wd[`MCGS_B_OSC125_OFF];
            end
            if (onchip_flag_q || fallback)
                ctl1_q[`MCGS_B_OSC125_OFF] <= 1'b0;
        end
    end

    // Detector controls and the on-chip source flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            det_en_q <= 1'b0;
            det_act_q <= 1'b0;
            onchip_flag_q <= `MCGS_RST_ONCHIP;
        end else begin
            if (wr && wb_req.adr == `MCGS_ADR_CTL2) begin
                if (!lock_q)
                    det_en_q <= wd[`MCGS_B_DET_EN];
                det_act_q <= wd[`MCGS_B_DET_ACT];
                if (!wd[`MCGS_B_ONCHIP_FLAG])
                    onchip_flag_q <= 1'b0;
            end
            if (fallback)
                onchip_flag_q <= 1'b1;
        end
    end

    // Oscillator, output-select, stop, key and misc registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc40_q <= `MCGS_RST_OSC40;
            clock_output_pin_f1_q <= 1'b0;
            pstop_q <= `MCGS_RST_PSTOP;
            key_q <= 1'b0;
            sdiv_q <= 2'h0;
            bclk_dis_q <= 1'b0;
            wdt_prot_q <= 1'b0;
        end else if (wr) begin
            case (wb_req.adr)
                `MCGS_ADR_OSC40:
                    osc40_q <= {6'h0, wd[`MCGS_B_ONCHIP_SEL],
                                wd[`MCGS_B_OSC40_EN]};
                `MCGS_ADR_PCLK: clock_output_pin_f1_q <= wd[`MCGS_B_CLOCK_OUTPUT_PIN_F1];
                `MCGS_ADR_PSTOP: pstop_q <= wd[`MCGS_NPERIPH-1:0];
                `MCGS_ADR_PROT: key_q <= wd[`MCGS_B_PM2_KEY];
                `MCGS_ADR_MISC: begin
                    sdiv_q <= wd[`MCGS_B_SDIV_HI:`MCGS_B_SDIV_LO];
                    bclk_dis_q <= wd[`MCGS_B_BCLK_DIS];
                    wdt_prot_q <= wd[`MCGS_B_WDT_PROT];
                end
                default: ;
            endcase
        end
    end

    // Lock register needs the key; software keeps the set order
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lock_q <= 1'b0;
            sub_feed_q <= 1'b0;
        end else if (wr && wb_req.adr == `MCGS_ADR_PM2 && key_q) begin
            lock_q <= wd[`MCGS_B_LOCK];
            sub_feed_q <= wd[`MCGS_B_SUB_FEED];
        end
    end

    // Requested CPU source and divisor
    always_comb begin
        if (onchip_flag_q)
            sel_src = osc40_q[`MCGS_B_ONCHIP_SEL] ? MCGS_SRC_O40H
                                                  : MCGS_SRC_O125;
        else if (ctl0_q[`MCGS_B_SRC_SUB])
            sel_src = MCGS_SRC_SUB;
        else
            sel_src = MCGS_SRC_MAIN;
        if (sel_src == MCGS_SRC_SUB)
            sel_div = sdiv_q[0] ? `MCGS_DIV_TWO : `MCGS_DIV_ONE;
        else
            sel_div = cpu_divisor(ctl0_q[`MCGS_B_DIV8],
                                  ctl1_q[`MCGS_B_DIVF_HI:`MCGS_B_DIVF_LO]);
    end

    logic [4:0] cur_div_q;
    logic [4:0] cpu_cnt_q;
    logic t_cur;
    logic t_f1;

    always_comb begin
        case (cur_src_q)
            MCGS_SRC_MAIN: t_cur = t_main;
            MCGS_SRC_O40H: t_cur = t_half;
            MCGS_SRC_O125: t_cur = t_osc125;
            MCGS_SRC_SUB: t_cur = t_sub;
            default: t_cur = 1'b0;
        endcase
    end

    // New source or divisor is taken only when a period completes, so
    // no shortened phase; a fallback switches at once since the dead
    // main clock would never complete its period.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cur_src_q <= MCGS_SRC_O125;
            cur_div_q <= `MCGS_RST_DIV;
            cpu_cnt_q <= 5'h0;
            cpu_clk_en <= 1'b0;
        end else begin
            cpu_clk_en <= 1'b0;
            if (fallback && cur_src_q == MCGS_SRC_MAIN) begin
                cur_src_q <= osc40_q[`MCGS_B_ONCHIP_SEL] ? MCGS_SRC_O40H
                                                         : MCGS_SRC_O125;
                cpu_cnt_q <= 5'h0;
            end else if (t_cur) begin
                if (cpu_cnt_q == cur_div_q - `MCGS_DIV_ONE) begin
                    cpu_cnt_q <= 5'h0;
                    cpu_clk_en <= 1'b1;
                    cur_src_q <= sel_src;
                    cur_div_q <= sel_div;
                end else
                    cpu_cnt_q <= cpu_cnt_q + 5'h1;
            end
        end
    end

    // Peripheral base clock: undivided main or on-chip source
    always_comb begin
        if (!onchip_flag_q)
            t_f1 = t_main;
        else if (osc40_q[`MCGS_B_ONCHIP_SEL])
            t_f1 = t_half;
        else
            t_f1 = t_osc125;
    end

    logic f1_gate;
    assign f1_gate = t_f1 & ~(wait_mode & ctl0_q[`MCGS_B_F1_STOP_WAIT]);

    logic [4:0] sub32_cnt_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            periph_base_en <= 1'b0;
            periph_clk_en <= '0;
            osc40_periph_en <= 1'b0;
            osc40_half_periph_en <= 1'b0;
            osc125_periph_en <= 1'b0;
            wdt_clk_en <= 1'b0;
            sub_feed_en <= 1'b0;
            sub_div32_en <= 1'b0;
            sub32_cnt_q <= 5'h0;
        end else begin
            periph_base_en <= f1_gate;
            periph_clk_en <= {`MCGS_NPERIPH{f1_gate}} & ~pstop_q;
            osc40_periph_en <= t_osc40;
            osc40_half_periph_en <= t_half;
            osc125_periph_en <= t_osc125;
            wdt_clk_en <= wdt_prot_q & t_osc125;
            sub_feed_en <= sub_feed_q & t_sub;
            sub_div32_en <= t_sub && sub32_cnt_q == `MCGS_DIV_SUB32;
            if (t_sub)
                sub32_cnt_q <= sub32_cnt_q + 5'h1;
        end
    end

    // Oscillator run levels
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc40_run <= 1'b0;
            osc125_run <= 1'b0;
            main_osc_run <= 1'b0;
            sub_osc_run <= 1'b0;
        end else begin
            osc40_run <= osc40_on;
            osc125_run <= osc125_on | onchip_flag_q;
            main_osc_run <= ~ctl0_q[`MCGS_B_MAIN_STOP];
            sub_osc_run <= sub_on & ~ctl0_q[`MCGS_B_SUB_OFF];
        end
    end

    // Pins toggle on each edge of the clock they carry
    logic [4:0] co_cnt_q;
    logic co_edge;
    logic [1:0] co_sel;
    assign co_sel = clock_output_pin_f1_q ? `MCGS_CO_F1
                  : ctl0_q[`MCGS_B_CLOCK_OUTPUT_PIN_HI:`MCGS_B_CLOCK_OUTPUT_PIN_LO];
    always_comb begin
        case (co_sel)
            `MCGS_CO_F1: co_edge = t_f1;
            `MCGS_CO_SUB: co_edge = t_sub;
            `MCGS_CO_F8: co_edge = t_f1 && co_cnt_q[2:0] == `MCGS_DIV_F8;
            `MCGS_CO_F32: co_edge = t_f1 && co_cnt_q == `MCGS_DIV_F32;
            default: co_edge = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            co_cnt_q <= 5'h0;
            clock_output_pin_o <= 1'b0;
            clock_output_pin_oe <= 1'b0;
            bus_clock_o <= 1'b0;
            bus_clock_oe <= 1'b0;
        end else begin
            if (t_f1)
                co_cnt_q <= co_cnt_q + 5'h1;
            clock_output_pin_oe <= ~ext_bus_mode;
            if (co_edge && !ext_bus_mode)
                clock_output_pin_o <= ~clock_output_pin_o;
            bus_clock_oe <= ext_bus_mode & ~bclk_dis_q;
            if (t_cur && cpu_cnt_q == cur_div_q - `MCGS_DIV_ONE &&
                ext_bus_mode && !bclk_dis_q)
                bus_clock_o <= ~bus_clock_o;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

endmodule

// [tb/mcgs_clock_gen_chk.sv]
// Checker: port-level assertions for mcgs_clock_gen.
// Assumes one clock domain; bound to every instance below.
`timescale 1ns/1ps
module mcgs_clock_gen_chk
    import mcgs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire mcgs_ticks_t src_tick,
    input wire logic ext_bus_mode,
    input wire logic cpu_clk_en,
    input wire logic periph_base_en,
    input wire logic osc40_periph_en,
    input wire logic osc40_half_periph_en,
    input wire logic wdt_clk_en,
    input wire logic sub_feed_en,
    input wire logic osc40_run,
    input wire logic bus_clock_oe,
    input wire logic clock_output_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Two samples, because the pin enables are registered
    sequence s_single;
        (!ext_bus_mode) [*2];
    endsequence
    sequence s_half;
        $past(src_tick.osc40) ##1 !osc40_half_periph_en;
    endsequence
    property p_osc40_rst; $fell(reset) |-> !osc40_run; endproperty
    a_osc40_rst: assert property (p_osc40_rst)
        else $error("osc40 running after reset");
    property p_cpu_tick; cpu_clk_en |-> $past(|src_tick); endproperty
    a_cpu_tick: assert property (p_cpu_tick)
        else $error("cpu edge without source edge");
    property p_half; osc40_half_periph_en |-> s_half; endproperty
    a_half: assert property (p_half)
        else $error("osc40 half edge not halved");
    property p_osc40_gate;
        osc40_periph_en |-> $past(src_tick.osc40)
            && osc40_run;
    endproperty
    a_osc40_gate: assert property (p_osc40_gate)
        else $error("osc40 edge while disabled");
    property p_wdt; wdt_clk_en |-> $past(src_tick.osc125); endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog edge not from osc125");
    property p_feed; sub_feed_en |-> $past(src_tick.sub); endproperty
    a_feed: assert property (p_feed)
        else $error("sub feed edge not from sub clock");
    property p_f1;
        periph_base_en |->
            $past(src_tick.main || src_tick.osc40 || src_tick.osc125);
    endproperty
    a_f1: assert property (p_f1)
        else $error("f1 edge without undivided source edge");
    property p_bus_oe; s_single |-> !bus_clock_oe; endproperty
    a_bus_oe: assert property (p_bus_oe)
        else $error("bus clock driven in single-chip mode");
    property p_pin_oe; s_single |-> clock_output_pin_oe; endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("clock pin not driven in single-chip mode");
endmodule

bind mcgs_clock_gen mcgs_clock_gen_chk u_chk (
    .clk, .reset, .src_tick, .ext_bus_mode, .cpu_clk_en, .periph_base_en,
    .osc40_periph_en, .osc40_half_periph_en, .wdt_clk_en, .sub_feed_en,
    .osc40_run, .bus_clock_oe, .clock_output_pin_oe);

// [tb/mcgs_clock_gen_tb.sv]
// Testbench for mcgs_clock_gen: registers, CPU periods, fallback, lock.
// Assumes ticks: main, osc40 every cycle, osc125 every 2nd, sub every 4th.
`timescale 1ns/1ps
`include "mcgs_defs.svh"
module mcgs_clock_gen_tb
    import mcgs_pkg::*;
;
    logic clk = 1'h0, reset = 1'h1;
    mcgs_wb_req_t wb_req = '0;
    mcgs_ticks_t src_tick = '0;
    logic main_stop_detect = 1'h0, wait_mode = 1'h0, ext_bus_mode = 1'h0;
    logic [31:0] wb_dat_o;
    logic [6:0] periph_clk_en, seen;
    logic wb_ack_o, cpu_clk_en, periph_base_en, osc40_periph_en;
    logic wdt_clk_en, sub_div32_en, sub_feed_en, stop_mode_req;
    logic bus_clock_o, bus_clock_oe, clock_output_pin_o, clock_output_pin_oe;
    logic osc125_periph_en;
    logic co_q = 1'h0, bc_q = 1'h0;
    int bad_count = 0, n_compared = 0, cyc = 0, last = 0, gap = 0;
    int n_co, n_bc, n_stop, n_wdt, n_feed, n_d32, n_o40, n_base, n_o125;

    mcgs_clock_gen dut (.clk, .reset, .wb_req, .wb_dat_o, .wb_ack_o,
        .src_tick, .main_stop_detect, .wait_mode, .ext_bus_mode,
        .cpu_clk_en, .periph_base_en, .periph_clk_en, .osc40_periph_en,
        .osc40_half_periph_en(), .osc125_periph_en, .wdt_clk_en,
        .sub_div32_en, .sub_feed_en, .osc40_run(), .osc125_run(),
        .main_osc_run(), .sub_osc_run(), .stop_mode_req, .bus_clock_o,
        .bus_clock_oe, .clock_output_pin_o, .clock_output_pin_oe);

    initial forever #25 clk = ~clk;

    // One process ticks and counts, so the cycle number never races
    always @(posedge clk) begin
        cyc++;
        src_tick <= '{1'h1, 1'h1, cyc[0], cyc[1:0] == 2'h0};
        if (cpu_clk_en) begin
            gap = cyc - last;
            last = cyc;
        end
        n_co += clock_output_pin_o != co_q;
        co_q = clock_output_pin_o;
        n_bc += bus_clock_o != bc_q;
        bc_q = bus_clock_o;
        n_stop += stop_mode_req;
        n_wdt += wdt_clk_en;
        n_feed += sub_feed_en;
        n_d32 += sub_div32_en;
        n_o40 += osc40_periph_en;
        n_o125 += osc125_periph_en;
        n_base += periph_base_en;
        seen |= periph_clk_en;
    end

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #4_000_000;
        bad_count++;
        print_verdict();
    end

    task automatic cmp(input string s, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q);
        @(posedge clk);
        wb_req <= '{1'h1, 1'h1, w, a, 4'h1, {24'h0, d}};
        @(posedge clk);
        while (wb_ack_o !== 1'h1) @(posedge clk);
        q = wb_dat_o[7:0];
        wb_req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        bus(1'h1, a, d, q);
    endtask

    task automatic rc(input string s, input logic [7:0] a, e);
        logic [7:0] q;
        bus(1'h0, a, 8'h00, q);
        cmp(s, e, q);
    endtask

    // Settles three edges first: pin paths lag the register write
    task automatic win(input int n);
        repeat (3) @(posedge clk);
        @(negedge clk);
        {n_co, n_bc, n_stop, n_wdt, n_feed, n_d32, n_o40, n_base} = '0;
        n_o125 = 0;
        seen = 7'h00;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic meas(input int e);
        repeat (3) @(posedge clk iff cpu_clk_en);
        @(negedge clk);
        cmp("cpu period", e, gap);
    endtask

    task automatic fail_main();
        @(posedge clk) main_stop_detect <= 1'h1;
        @(posedge clk) main_stop_detect <= 1'h0;
    endtask

    function automatic int div_exp(input logic d8, input logic [1:0] f);
        return d8 ? 8 : (f == 2'h3 ? 16 : 1 << f);
    endfunction

    // Toggles in 256 cycles: f1, sub, f1/8, f1/32
    function automatic int co_exp(input logic [1:0] f);
        return f == 2'h1 ? 64 : 256 >> (f == 2'h0 ? 0 : f == 2'h2 ? 3 : 5);
    endfunction

    initial begin
        logic [6:0] r;
        void'($urandom(69));
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        rc("ctl0", `MCGS_ADR_CTL0, 8'h48);
        rc("ctl1", `MCGS_ADR_CTL1, 8'h00);
        rc("osc40", `MCGS_ADR_OSC40, 8'h00);
        rc("stat", `MCGS_ADR_STAT, 8'hA2);
        wr(8'h3C, 8'hFF);
        rc("hole", 8'h3C, 8'h00);
        meas(div_exp(1'h1, 2'h0) * 2);
        wr(`MCGS_ADR_CTL2, 8'h00);
        meas(div_exp(1'h1, 2'h0));
        rc("stat", `MCGS_ADR_STAT, 8'hA0);
        wr(`MCGS_ADR_CTL0, 8'h18);
        for (int f = 0; f < 4; f++) begin
            wr(`MCGS_ADR_CTL1, 8'(f << 6));
            meas(div_exp(1'h0, f[1:0]));
        end
        for (int f = 0; f < 4; f++) begin
            wr(`MCGS_ADR_PCLK, f == 0 ? 8'h20 : 8'h00);
            wr(`MCGS_ADR_CTL0, 8'h18 | 8'(f));
            win(256);
            cmp("pin toggles", co_exp(f[1:0]), n_co);
            cmp("div32", 2, n_d32);
            cmp("feed", 0, n_feed);
        end
        @(posedge clk) ext_bus_mode <= 1'h1;
        win(256);
        cmp("bclk oe", 1'h1, bus_clock_oe);
        cmp("bclk toggles", 256 / div_exp(1'h0, 2'h3), n_bc);
        cmp("pin oe", 1'h0, clock_output_pin_oe);
        wr(`MCGS_ADR_MISC, 8'h10);
        win(4);
        cmp("bclk oe", 1'h0, bus_clock_oe);
        @(posedge clk) ext_bus_mode <= 1'h0;
        wr(`MCGS_ADR_MISC, 8'h00);
        wr(`MCGS_ADR_CTL0, 8'h90);
        meas(4);
        rc("stat", `MCGS_ADR_STAT, 8'hE3);
        wr(`MCGS_ADR_MISC, 8'h01);
        meas(8);
        wr(`MCGS_ADR_CTL0, 8'h18);
        wr(`MCGS_ADR_PROT, 8'h02);
        wr(`MCGS_ADR_PM2, 8'h20);
        win(64);
        cmp("feed", 16, n_feed);
        wr(`MCGS_ADR_PM2, 8'h22);
        wr(`MCGS_ADR_PROT, 8'h00);
        wr(`MCGS_ADR_PM2, 8'h00);
        rc("pm2", `MCGS_ADR_PM2, 8'h22);
        wr(`MCGS_ADR_CTL0, 8'hB4);
        rc("ctl0", `MCGS_ADR_CTL0, 8'h10);
        wr(`MCGS_ADR_CTL2, 8'h81);
        rc("ctl2", `MCGS_ADR_CTL2, 8'h80);
        win(1);
        wr(`MCGS_ADR_CTL1, 8'hC1);
        repeat (2) @(negedge clk);
        cmp("stop req", 0, n_stop);
        wr(`MCGS_ADR_PROT, 8'h02);
        wr(`MCGS_ADR_PM2, 8'h20);
        wr(`MCGS_ADR_PROT, 8'h00);
        win(1);
        wr(`MCGS_ADR_CTL1, 8'hC1);
        rc("ctl0", `MCGS_ADR_CTL0, 8'h50);
        cmp("stop req", 1, n_stop);
        wr(`MCGS_ADR_CTL2, 8'h81);
        wr(`MCGS_ADR_OSC40, 8'h03);
        win(32);
        cmp("osc40 feed", 32, n_o40);
        fail_main();
        rc("stat", `MCGS_ADR_STAT, 8'hF1);
        meas(div_exp(1'h1, 2'h0) * 2);
        wr(`MCGS_ADR_CTL2, 8'h81);
        meas(div_exp(1'h1, 2'h0));
        wr(`MCGS_ADR_OSC40, 8'h01);
        wr(`MCGS_ADR_OSC40, 8'h00);
        win(32);
        cmp("osc40 feed", 0, n_o40);
        fail_main();
        wr(`MCGS_ADR_CTL1, 8'hD0);
        rc("ctl1", `MCGS_ADR_CTL1, 8'hC0);
        rc("stat", `MCGS_ADR_STAT, 8'hE2);
        meas(div_exp(1'h1, 2'h3) * 2);
        wr(`MCGS_ADR_MISC, 8'h80);
        win(32);
        cmp("wdt", 16, n_wdt);
        cmp("osc125", 16, n_o125);
        wr(`MCGS_ADR_MISC, 8'h00);
        win(32);
        cmp("wdt", 0, n_wdt);
        repeat (3) begin
            r = 7'($urandom);
            wr(`MCGS_ADR_PSTOP, {1'h0, r});
            win(16);
            cmp("groups", {25'h0, ~r}, {25'h0, seen});
        end
        wr(`MCGS_ADR_CTL0, 8'h54);
        @(posedge clk) wait_mode <= 1'h1;
        win(16);
        cmp("f1 in wait", 0, n_base);
        @(posedge clk) wait_mode <= 1'h0;
        win(16);
        cmp("f1 after wait", 8, n_base);
        print_verdict();
    end
endmodule
